// >>> fjm_cfg.svh
// constants for the feeder jam monitor: distances, scales, codes
`ifndef FJM_CFG_SVH
`define FJM_CFG_SVH
// ----------------------------------------------------------------
// feed distance scale
// ----------------------------------------------------------------
`define FJM_PULSES_PER_MM     8'd4
// ----------------------------------------------------------------
// window lengths in millimetres
// ----------------------------------------------------------------
`define FJM_MM_SEP_LATE       16'd224
`define FJM_MM_SKEW_LATE      16'd46
`define FJM_MM_GRIP_LATE      16'd172
`define FJM_MM_REG_LATE       16'd96
`define FJM_MM_EXIT_LATE      16'd130
`define FJM_MM_SKEW_LAG       16'd46
`define FJM_MM_RELAY_LAG      16'd82
`define FJM_MM_REG_LAG        16'd93
`define FJM_MM_EXIT_LAG       16'd130
`define FJM_MM_STD_LENGTH     16'd297
// ----------------------------------------------------------------
// jam codes
// ----------------------------------------------------------------
`define FJM_JAM_NONE          7'd0
`define FJM_JAM_SEP_LATE      7'd13
`define FJM_JAM_SKEW_LATE     7'd14
`define FJM_JAM_GRIP_LATE     7'd15
`define FJM_JAM_REG_LATE      7'd16
`define FJM_JAM_EXIT_LATE     7'd17
`define FJM_JAM_SEP_LAG       7'd63
`define FJM_JAM_SKEW_LAG      7'd64
`define FJM_JAM_RELAY_LAG     7'd65
`define FJM_JAM_REG_LAG       7'd66
`define FJM_JAM_EXIT_LAG      7'd67
`define FJM_JAM_DOUBLE        7'd99
// ----------------------------------------------------------------
// fault bit positions and window count
// ----------------------------------------------------------------
`define FJM_FLT_LIFT          0
`define FJM_FLT_DFEED         1
`define FJM_FLT_CIS_COMM      2
`define FJM_FLT_CIS_GRAY      3
`define FJM_NUM_FLT           4
`define FJM_NUM_WIN           10
`endif

// >>> fjm_feeder_jam_monitor.sv
// feeder jam monitor: feed-distance windows, jam latch, fault latches
// Operation
// (R1) feed motor start: jam 13 if no separation leading edge within 224 mm
// (R2) separation leading edge: jam 14 if skew sensor misses it within 46 mm
// (R3) grip motor pull-out: jam 15 if no skew leading edge within 172 mm
// (R4) skew leading edge: jam 16 if registration misses it within 96 mm
// (R5) registration leading edge: jam 17 if exit misses it within 130 mm
// (R6) lag jam 63 window is standard length times 1.5; operator length overrides
// (R7) separation trailing edge: jam 64 if skew trailing edge not within 46 mm
// (R8) relay motor stop: jam 65 if no skew trailing edge within 82 mm
// (R9) skew trailing edge: jam 66 if registration trailing not within 93 mm
// (R10) registration trailing edge: jam 67 if exit trailing not within 130 mm
// (R11) weak ultrasonic level for the original raises jam 99
// (R12) same error twice in a row is jam, three times is service call
// (R13) bottom plate lift failure latches fault 700-01 until power cycle
// (R14) double-feed circuit or sensor failure reports fault 703-01
// (R15) back-side image sensor link failure latches 185-00 until power cycle
// (R16) image sensor gray balance failure latches 189-00 until power cycle
// (R17) double feed issues jam 99 and then stops original feeding
// (R18) windows count motor pulses from the trigger, mm times fixed scale
// (R19) any jam stops the feed motors and latches the code until acknowledged
`timescale 1ns/10ps
`include "fjm_cfg.svh"
module fjm_feeder_jam_monitor
    import fjm_pkg::*;
(
    input  wire logic        clk_sys_in,         // 50 MHz system clock
    input  wire logic        rst_b_in,           // synchronous reset, active low
    input  wire logic        motor_pulse_in,     // one pulse per drive motor step
    input  wire logic        feed_start_in,      // feed motor started, pulse
    input  wire logic        grip_start_in,      // grip motor pull-out started, pulse
    input  wire logic        relay_stop_in,      // relay motor stopped, pulse
    input  wire logic        sep_sensor_in,      // separation sensor, high = paper
    input  wire logic        skew_sensor_in,     // skew correction sensor
    input  wire logic        reg_sensor_in,      // registration sensor
    input  wire logic        exit_sensor_in,     // exit sensor
    input  wire logic        dfeed_weak_in,      // ultrasonic level below single sheet
    input  wire logic        dfeed_enable_in,    // double-feed detection switched on
    input  wire logic [15:0] orig_len_mm_in,     // operator original length, 0 = unset
    input  wire logic        lift_fail_in,       // bottom plate lift abnormal
    input  wire logic        dfeed_circ_fail_in, // double-feed circuit abnormal
    input  wire logic        cis_comm_fail_in,   // image sensor link failure
    input  wire logic        cis_gray_fail_in,   // gray balance failure
    input  wire logic        jam_ack_in,         // host acknowledges jam, pulse
    output logic             feed_stop_out,      // stop all feed motors
    output logic             jam_valid_out,      // a jam code is latched
    output logic [6:0]       jam_code_out,       // latched jam code
    output logic             repeat_jam_out,     // same error seen twice in a row
    output logic             service_call_error_out, // same error three times in a row
    output logic [3:0]       fault_out           // 700-01, 703-01, 185-00, 189-00
);
    // ----------------------------------------------------------------
    // edge detection on the path sensors
    // ----------------------------------------------------------------
    logic [3:0] sens_q;
    wire  [3:0] sens_now = {exit_sensor_in, reg_sensor_in, skew_sensor_in, sep_sensor_in};
    wire  [3:0] lead_w   = sens_now & ~sens_q;
    wire  [3:0] trail_w  = ~sens_now & sens_q;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) sens_q <= 4'h0;
        else           sens_q <= sens_now;
    end

    // ----------------------------------------------------------------
    // window table: start, satisfying edge, limit in mm, code
    // ----------------------------------------------------------------
    // lag 63 window: length * 1.5 computed as len + len/2, no multiplier needed
    wire [15:0] std_len_w = (orig_len_mm_in != 16'h0000) ? orig_len_mm_in : `FJM_MM_STD_LENGTH; // R6
    wire [15:0] lag63_mm  = std_len_w + {1'b0, std_len_w[15:1]}; // R6

    wire [`FJM_NUM_WIN-1:0] win_start;
    wire [`FJM_NUM_WIN-1:0] win_done;
    wire [15:0]             win_mm   [`FJM_NUM_WIN];
    wire [6:0]              win_code [`FJM_NUM_WIN];

    assign win_start[0] = feed_start_in;  assign win_done[0] = lead_w[0];   // R1
    assign win_start[1] = lead_w[0];      assign win_done[1] = lead_w[1];   // R2
    assign win_start[2] = grip_start_in;  assign win_done[2] = lead_w[1];   // R3
    assign win_start[3] = lead_w[1];      assign win_done[3] = lead_w[2];   // R4
    assign win_start[4] = lead_w[2];      assign win_done[4] = lead_w[3];   // R5
    assign win_start[5] = grip_start_in;  assign win_done[5] = trail_w[0];  // R6
    assign win_start[6] = trail_w[0];     assign win_done[6] = trail_w[1];  // R7
    assign win_start[7] = relay_stop_in;  assign win_done[7] = trail_w[1];  // R8
    assign win_start[8] = trail_w[1];     assign win_done[8] = trail_w[2];  // R9
    assign win_start[9] = trail_w[2];     assign win_done[9] = trail_w[3];  // R10

    assign win_mm[0] = `FJM_MM_SEP_LATE;   assign win_code[0] = `FJM_JAM_SEP_LATE;
    assign win_mm[1] = `FJM_MM_SKEW_LATE;  assign win_code[1] = `FJM_JAM_SKEW_LATE;
    assign win_mm[2] = `FJM_MM_GRIP_LATE;  assign win_code[2] = `FJM_JAM_GRIP_LATE;
    assign win_mm[3] = `FJM_MM_REG_LATE;   assign win_code[3] = `FJM_JAM_REG_LATE;
    assign win_mm[4] = `FJM_MM_EXIT_LATE;  assign win_code[4] = `FJM_JAM_EXIT_LATE;
    assign win_mm[5] = lag63_mm;           assign win_code[5] = `FJM_JAM_SEP_LAG;
    assign win_mm[6] = `FJM_MM_SKEW_LAG;   assign win_code[6] = `FJM_JAM_SKEW_LAG;
    assign win_mm[7] = `FJM_MM_RELAY_LAG;  assign win_code[7] = `FJM_JAM_RELAY_LAG;
    assign win_mm[8] = `FJM_MM_REG_LAG;    assign win_code[8] = `FJM_JAM_REG_LAG;
    assign win_mm[9] = `FJM_MM_EXIT_LAG;   assign win_code[9] = `FJM_JAM_EXIT_LAG;

    // ----------------------------------------------------------------
    // per-window pulse counters
    // ----------------------------------------------------------------
    fjm_state_t state_q;
    wire        running = (state_q == FJM_RUN);
    logic [`FJM_NUM_WIN-1:0] win_expired;

    genvar gi;
    generate
        for (gi = 0; gi < `FJM_NUM_WIN; gi++) begin : g_win
            logic        act_q;
            logic [23:0] cnt_q;
            // limit in pulses: millimetres times the motor scale
            wire  [23:0] limit = {8'h00, win_mm[gi]} * {16'h0000, `FJM_PULSES_PER_MM};   // R18
            assign win_expired[gi] = act_q && (cnt_q >= limit);
            always_ff @(posedge clk_sys_in) begin
                if (!rst_b_in || !running) begin
                    act_q <= 1'b0;
                    cnt_q <= 24'h0;
                end else if (win_start[gi]) begin   // restart wins over a stale window
                    act_q <= 1'b1;
                    cnt_q <= 24'h0;
                end else if (win_done[gi]) begin
                    act_q <= 1'b0;
                end else if (act_q && motor_pulse_in) begin
                    cnt_q <= cnt_q + 24'h1;          // R18
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // jam selection: lowest window wins, double feed last
    // ----------------------------------------------------------------
    logic [6:0] new_code;
    always_comb begin
        new_code = `FJM_JAM_NONE;
        if (dfeed_enable_in && dfeed_weak_in && sens_now[0])
            new_code = `FJM_JAM_DOUBLE;              // R11 R17
        for (int i = `FJM_NUM_WIN - 1; i >= 0; i--) begin
            if (win_expired[i])
                new_code = win_code[i];
        end
    end
    wire jam_hit = running && (new_code != `FJM_JAM_NONE);

    // ----------------------------------------------------------------
    // jam latch, repeat counting and motor stop
    // ----------------------------------------------------------------
    logic [6:0] last_code_q;
    logic [1:0] repeat_q;
    wire  [1:0] repeat_d = (new_code == last_code_q) ?
                           ((repeat_q == 2'd3) ? 2'd3 : repeat_q + 2'd1) : 2'd1; // R12
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state_q       <= FJM_RUN;
            jam_code_out  <= `FJM_JAM_NONE;
            jam_valid_out <= 1'b0;
            feed_stop_out <= 1'b0;
            last_code_q   <= `FJM_JAM_NONE;
            repeat_q      <= 2'd0;
        end else begin
            case (state_q)
                FJM_RUN: begin
                    if (jam_hit) begin               // R19 R17
                        state_q       <= FJM_HALT;
                        jam_code_out  <= new_code;
                        jam_valid_out <= 1'b1;
                        feed_stop_out <= 1'b1;
                        last_code_q   <= new_code;
                        repeat_q      <= repeat_d;   // R12
                    end
                end
                FJM_HALT: begin
                    if (jam_ack_in) begin            // R19
                        state_q       <= FJM_RUN;
                        jam_valid_out <= 1'b0;
                        feed_stop_out <= 1'b0;
                    end
                end
                default: state_q <= FJM_RUN;
            endcase
        end
    end

    // escalation levels; service call holds until reset, like the faults
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            repeat_jam_out         <= 1'b0;
            service_call_error_out <= 1'b0;
        end else begin
            repeat_jam_out         <= (repeat_q >= 2'd2);   // R12
            service_call_error_out <= service_call_error_out | (repeat_q == 2'd3); // R12
        end
    end

    // ----------------------------------------------------------------
    // fault latches: cleared only by reset, i.e. a power cycle
    // ----------------------------------------------------------------
    wire [3:0] fault_set = {cis_gray_fail_in, cis_comm_fail_in, dfeed_circ_fail_in, lift_fail_in};
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) fault_out <= 4'h0;
        else           fault_out <= fault_out | fault_set; // R13 R14 R15 R16
    end

endmodule : fjm_feeder_jam_monitor

// >>> fjm_feeder_jam_monitor_sva.sv
// port-level checks for the feeder jam monitor
`timescale 1ns/10ps
module fjm_monitor_sva (
    input wire logic       clk_sys_in,             // system clock
    input wire logic       rst_b_in,               // reset, active low
    input wire logic       sep_sensor_in,          // separation sensor
    input wire logic       dfeed_weak_in,          // weak ultrasonic level
    input wire logic       dfeed_enable_in,        // double-feed detection on
    input wire logic       lift_fail_in,           // lift fault
    input wire logic       dfeed_circ_fail_in,     // double-feed circuit fault
    input wire logic       cis_comm_fail_in,       // sensor link fault
    input wire logic       cis_gray_fail_in,       // gray balance fault
    input wire logic       jam_ack_in,             // jam acknowledge
    input wire logic       feed_stop_out,          // motor stop
    input wire logic       jam_valid_out,          // jam latched
    input wire logic [6:0] jam_code_out,           // jam code
    input wire logic       repeat_jam_out,         // repeated error
    input wire logic       service_call_error_out, // third repeat
    input wire logic [3:0] fault_out               // fault latches
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    // fault inputs packed in output bit order
    wire logic [3:0] fail_w = {cis_gray_fail_in, cis_comm_fail_in, dfeed_circ_fail_in, lift_fail_in};
    stop_follows_jam_a: assert property (feed_stop_out == jam_valid_out) else $error("stop differs from jam");
    ack_clears_a: assert property (jam_valid_out && jam_ack_in |=> !jam_valid_out) else $error("ack ignored");
    code_holds_a: assert property (jam_valid_out && !jam_ack_in |=> jam_valid_out && $stable(jam_code_out))
        else $error("jam code not held");
    code_nonzero_a: assert property (jam_valid_out |-> jam_code_out != 7'h00) else $error("empty jam code");
    fault_sets_a: assert property (fail_w != 4'h0 |=> (fault_out & $past(fail_w)) == $past(fail_w))
        else $error("fault not latched");
    fault_sticky_a: assert property (##1 (fault_out & $past(fault_out)) == $past(fault_out))
        else $error("fault cleared");
    service_sticky_a: assert property (service_call_error_out |=> service_call_error_out)
        else $error("service call cleared");
    service_repeat_a: assert property ($rose(service_call_error_out) |-> repeat_jam_out)
        else $error("service call without repeat");
    dfeed_jam_a: assert property (!jam_valid_out && sep_sensor_in && dfeed_weak_in && dfeed_enable_in
        |=> jam_valid_out && feed_stop_out) else $error("double feed missed");
    // main scenarios
    jam_seen_c: cover property ($rose(jam_valid_out));
    service_seen_c: cover property ($rose(service_call_error_out));
    fault_seen_c: cover property (fault_out == 4'hF);
    lag_seen_c: cover property ($rose(jam_valid_out) && jam_code_out == 7'd63);
endmodule : fjm_monitor_sva
bind fjm_feeder_jam_monitor fjm_monitor_sva i_fjm_monitor_sva (
    .clk_sys_in             (clk_sys_in),
    .rst_b_in               (rst_b_in),
    .sep_sensor_in          (sep_sensor_in),
    .dfeed_weak_in          (dfeed_weak_in),
    .dfeed_enable_in        (dfeed_enable_in),
    .lift_fail_in           (lift_fail_in),
    .dfeed_circ_fail_in     (dfeed_circ_fail_in),
    .cis_comm_fail_in       (cis_comm_fail_in),
    .cis_gray_fail_in       (cis_gray_fail_in),
    .jam_ack_in             (jam_ack_in),
    .feed_stop_out          (feed_stop_out),
    .jam_valid_out          (jam_valid_out),
    .jam_code_out           (jam_code_out),
    .repeat_jam_out         (repeat_jam_out),
    .service_call_error_out (service_call_error_out),
    .fault_out              (fault_out)
);

// >>> fjm_path_model.sv
// paper path partner: drive motor step pulses on request
`timescale 1ns/10ps
module fjm_path_model (
    input  wire logic clk_sys_in,      // system clock
    output logic      motor_pulse_out  // one drive step per high cycle
);
    // steps change on the falling edge so the monitor samples settled levels
    task automatic step(input int n);
        repeat (n) begin
            @(negedge clk_sys_in);
            motor_pulse_out = 1'b1;
        end
        @(negedge clk_sys_in);
        motor_pulse_out = 1'b0;
    endtask : step
    initial motor_pulse_out = 1'b0;
endmodule : fjm_path_model

// >>> fjm_pkg.sv
// types for the feeder jam monitor
package fjm_pkg;
    typedef enum logic [1:0] {
        FJM_RUN,
        FJM_HALT
    } fjm_state_t;
endpackage : fjm_pkg

// >>> tb_feeder_jam_monitor.sv
// self-checking bench for the feeder jam monitor
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_feeder_jam_monitor;
    logic       clk_sys_in = 1'b0;
    logic       rst_b_in, motor_pulse, feed_start_in, grip_start_in, relay_stop_in;
    logic       exit_sensor_in;
    logic [15:0] orig_len_mm_in;
    logic       sep_sensor_in, skew_sensor_in, reg_sensor_in, dfeed_weak_in, dfeed_enable_in, jam_ack_in;
    logic [3:0] fail, fault_out;
    logic       feed_stop_out, jam_valid_out, repeat_jam_out, service_call_error_out;
    logic [6:0] jam_code_out;
    int         n_mismatch = 0, cmp_count = 0;
    fjm_path_model i_fjm_path_model (.clk_sys_in(clk_sys_in), .motor_pulse_out(motor_pulse));
    fjm_feeder_jam_monitor i_fjm_feeder_jam_monitor (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .motor_pulse_in(motor_pulse), .feed_start_in(feed_start_in), .grip_start_in(grip_start_in),
        .relay_stop_in(relay_stop_in), .sep_sensor_in(sep_sensor_in), .skew_sensor_in(skew_sensor_in),
        .reg_sensor_in(reg_sensor_in), .exit_sensor_in(exit_sensor_in), .dfeed_weak_in(dfeed_weak_in),
        .dfeed_enable_in(dfeed_enable_in), .orig_len_mm_in(orig_len_mm_in), .lift_fail_in(fail[0]),
        .dfeed_circ_fail_in(fail[1]), .cis_comm_fail_in(fail[2]), .cis_gray_fail_in(fail[3]),
        .jam_ack_in(jam_ack_in), .feed_stop_out(feed_stop_out), .jam_valid_out(jam_valid_out),
        .jam_code_out(jam_code_out), .repeat_jam_out(repeat_jam_out),
        .service_call_error_out(service_call_error_out), .fault_out(fault_out));
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : tick
    // wait a bounded time for a latched jam, then let the repeat flags settle
    task automatic wait_jam;
        int k;
        k = 0;
        while (jam_valid_out !== 1'b1 && k < 6) begin
            tick(1);
            k++;
        end
        tick(2);
    endtask : wait_jam
    task automatic ack;
        jam_ack_in = 1'b1;
        tick(1);
        jam_ack_in = 1'b0;
        tick(1);
        `CHK("jam valid after ack", 1'b0, jam_valid_out)
    endtask : ack
    // one window: trigger, one pulse short of the limit, then the last pulse
    task automatic jam_case(input logic [6:0] code, input int mm, input logic rep, input logic svc);
        case (code)
            7'd13: feed_start_in = 1'b1;
            7'd14: sep_sensor_in = 1'b1;
            7'd15: grip_start_in = 1'b1;
            7'd16: skew_sensor_in = 1'b1;
            7'd17: reg_sensor_in = 1'b1;
            7'd64: sep_sensor_in = 1'b0;
            7'd65: relay_stop_in = 1'b1;
            7'd66: skew_sensor_in = 1'b0;
            default: reg_sensor_in = 1'b0;
        endcase
        tick(1);
        {feed_start_in, grip_start_in, relay_stop_in} = 3'h0;
        i_fjm_path_model.step(mm * 4 - 1);
        tick(3);
        `CHK("early jam", 1'b0, jam_valid_out)
        i_fjm_path_model.step(1);
        wait_jam();
        `CHK("jam code", code, jam_code_out)
        `CHK("feed stop", 1'b1, feed_stop_out)
        `CHK("repeat jam", rep, repeat_jam_out)
        `CHK("service call", svc, service_call_error_out)
        ack();
    endtask : jam_case
    // a sheet whose every edge arrives in time must pass without a jam
    task automatic clean_sheet;
        feed_start_in = 1'b1;
        tick(1);
        feed_start_in = 1'b0;
        i_fjm_path_model.step(100);
        sep_sensor_in = 1'b1;
        i_fjm_path_model.step(100);
        skew_sensor_in = 1'b1;
        i_fjm_path_model.step(300);
        reg_sensor_in = 1'b1;
        i_fjm_path_model.step(400);
        exit_sensor_in = 1'b1;
        i_fjm_path_model.step(50);
        `CHK("leading edges on time", 1'b0, jam_valid_out)
        sep_sensor_in = 1'b0;
        i_fjm_path_model.step(100);
        skew_sensor_in = 1'b0;
        i_fjm_path_model.step(300);
        reg_sensor_in = 1'b0;
        i_fjm_path_model.step(400);
        exit_sensor_in = 1'b0;
        i_fjm_path_model.step(600);
        `CHK("trailing edges on time", 1'b0, jam_valid_out)
    endtask : clean_sheet
    // lag window from grip start; the leading edges close the late windows first
    task automatic lag_jam(input logic [15:0] len, input int mm, input logic rep);
        orig_len_mm_in = len;
        grip_start_in = 1'b1;
        tick(1);
        grip_start_in = 1'b0;
        skew_sensor_in = 1'b1;
        tick(1);
        reg_sensor_in = 1'b1;
        tick(1);
        exit_sensor_in = 1'b1;
        tick(1);
        i_fjm_path_model.step(mm * 4 - 1);
        tick(3);
        `CHK("early lag jam", 1'b0, jam_valid_out)
        i_fjm_path_model.step(1);
        wait_jam();
        `CHK("lag jam code", 7'd63, jam_code_out)
        `CHK("lag repeat jam", rep, repeat_jam_out)
        ack();
        // lower one sensor per cycle so each trailing window closes at once
        skew_sensor_in = 1'b0;
        tick(1);
        reg_sensor_in = 1'b0;
        tick(1);
        exit_sensor_in = 1'b0;
        tick(1);
    endtask : lag_jam
    // weak level ignored while detection is off, jams once switched on
    task automatic double_feed;
        sep_sensor_in = 1'b1;
        dfeed_weak_in = 1'b1;
        tick(3);
        `CHK("jam while disabled", 1'b0, jam_valid_out)
        dfeed_enable_in = 1'b1;
        tick(1);
        dfeed_weak_in = 1'b0;
        wait_jam();
        `CHK("double feed code", 7'd99, jam_code_out)
        `CHK("double feed stop", 1'b1, feed_stop_out)
        ack();
    endtask : double_feed
    // each fault input pulses once; every bit must stay set afterwards
    task automatic faults;
        int b;
        for (b = 0; b < 4; b++) begin
            fail = 4'h1 << b;
            tick(2);
            fail = 4'h0;
            tick(2);
            `CHK("fault latch", (4'h2 << b) - 4'h1, fault_out)
        end
    endtask : faults
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    // watchdog: the full run needs about 11000 cycles
    initial begin
        #400000;
        n_mismatch++;
        test_done();
    end
    initial begin
        {rst_b_in, feed_start_in, grip_start_in, relay_stop_in, sep_sensor_in, skew_sensor_in} = 6'h00;
        {reg_sensor_in, dfeed_weak_in, dfeed_enable_in, jam_ack_in, fail} = 8'h00;
        {exit_sensor_in, orig_len_mm_in} = 17'h00000;
        tick(2);
        rst_b_in = 1'b1;
        tick(1);
        `CHK("jam after reset", 1'b0, jam_valid_out)
        jam_case(7'd13, 224, 1'b0, 1'b0);
        jam_case(7'd13, 224, 1'b1, 1'b0);
        jam_case(7'd13, 224, 1'b1, 1'b1);
        jam_case(7'd14, 46, 1'b0, 1'b1);
        jam_case(7'd15, 172, 1'b0, 1'b1);
        jam_case(7'd16, 96, 1'b0, 1'b1);
        jam_case(7'd17, 130, 1'b0, 1'b1);
        jam_case(7'd64, 46, 1'b0, 1'b1);
        jam_case(7'd65, 82, 1'b0, 1'b1);
        jam_case(7'd66, 93, 1'b0, 1'b1);
        jam_case(7'd67, 130, 1'b0, 1'b1);
        clean_sheet();
        lag_jam(16'd0, 445, 1'b0);
        lag_jam(16'd100, 150, 1'b1);
        double_feed();
        faults();
        test_done();
    end
endmodule : tb_feeder_jam_monitor
